// File: design/pin_route_pkg.sv
// =====================================================================
// shared constants and carriers for the pin drive routing block
// =====================================================================
package pin_route_pkg;

  // =====================================================================
  // sizes
  // =====================================================================
  localparam int unsigned NUM_PINS = 14;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned FIELDS_PER_REG = 5;
  localparam int unsigned NUM_SEL_REGS = 3;
  localparam int unsigned NUM_MISC = 9;
  localparam int unsigned NUM_IRQ_SRC = 23;   // 14 pins, then 9 misc lines

  // =====================================================================
  // register byte offsets on the wishbone bus
  // =====================================================================
  localparam logic [7:0] OFS_SEL0 = 8'h00;
  localparam logic [7:0] OFS_SEL1 = 8'h04;
  localparam logic [7:0] OFS_SEL2 = 8'h08;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PULLUP = 8'h10;
  localparam logic [7:0] OFS_LATCH = 8'h14;
  localparam logic [7:0] OFS_LATCH_SHADOW = 8'h18;
  localparam logic [7:0] OFS_RISE_MASK = 8'h1c;
  localparam logic [7:0] OFS_FALL_MASK = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [5:0] SEL_RST = 6'h00;
  localparam logic [13:0] PULLUP_RST = 14'h3fff;
  localparam logic [22:0] RISE_MASK_RST = 23'h000000;
  localparam logic [22:0] FALL_MASK_RST = 23'h000000;
  localparam logic [22:0] IRQ_MASK_RST = 23'h7fffff;

  // =====================================================================
  // drive enable selection codes
  // =====================================================================
  localparam logic [5:0] CODE_LOW = 6'h00;
  localparam logic [5:0] CODE_HIGH = 6'h01;
  localparam logic [5:0] CODE_MISC_LO = 6'h02;
  localparam logic [5:0] CODE_TIMER = 6'h05;
  localparam logic [5:0] CODE_SERIAL = 6'h08;
  localparam logic [5:0] CODE_SPI_A = 6'h0a;
  localparam logic [5:0] CODE_SPI_B = 6'h11;
  localparam logic [5:0] CODE_FLAG = 6'h18;
  localparam logic [5:0] CODE_TW_DATA = 6'h24;
  localparam logic [5:0] CODE_TW_CLK = 6'h25;
  localparam logic [5:0] CODE_MISC_HI = 6'h26;
  localparam logic [5:0] CODE_RESERVED = 6'h2c;
  localparam logic [5:0] MISC_HI_BASE = 6'h03;

  // =====================================================================
  // carriers
  // =====================================================================
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [8:0] misc_control_out;
    logic [2:0] timer_pin_enable;
    logic [1:0] serial_tx_pin_enable;
    logic [6:0] spi_port_a_enable;     // miso, mosi, clock, select 0..3
    logic [6:0] spi_port_b_enable;
    logic [11:0] general_flag_pin_enable;  // flags 4..15
    logic two_wire_data_enable;
    logic two_wire_clock_enable;
  } enable_src_t;

endpackage

// File: design/peripheral_pin_drive_routing.sv
`timescale 1ns/1ps
module peripheral_pin_drive_routing
  import pin_route_pkg::*;
(
  input wire logic mclk,                                 // 125 mhz clock
  input wire logic rst_n,                                // sync reset, low
  input pin_route_pkg::wb_req_t wb_req,                  // wishbone request
  output logic [31:0] wb_dat_o,                          // read data
  output logic wb_ack_o,                                 // transfer ack
  input pin_route_pkg::enable_src_t en_src,              // peripheral enables
  input wire logic [13:0] pin_buffer_input,              // per-pin out data
  input wire logic [13:0] pin_in,                        // pad levels
  output logic [13:0] pin_out,                           // pad out data
  output logic [13:0] pin_oe,                            // pad drive enable
  output logic [13:0] pin_pullup,                        // pad pull-up on
  output logic combined_interface_interrupt              // level interrupt
);
  import pin_route_pkg::*;

  // =====================================================================
  // helpers
  // =====================================================================
  // one drive enable from a selection code; reserved codes give low
  function automatic logic sel_enable(input logic [5:0] code, input enable_src_t s);
    logic r;
    r = 1'b0;
    if (code == CODE_HIGH)
    begin
      r = 1'b1;
    end
    else if (code >= CODE_MISC_LO && code < CODE_TIMER)
    begin
      r = s.misc_control_out[4'(code - CODE_MISC_LO)];
    end
    else if (code >= CODE_TIMER && code < CODE_SERIAL)
    begin
      r = s.timer_pin_enable[2'(code - CODE_TIMER)];
    end
    else if (code >= CODE_SERIAL && code < CODE_SPI_A)
    begin
      r = s.serial_tx_pin_enable[1'(code - CODE_SERIAL)];
    end
    else if (code >= CODE_SPI_A && code < CODE_SPI_B)
    begin
      r = s.spi_port_a_enable[3'(code - CODE_SPI_A)];
    end
    else if (code >= CODE_SPI_B && code < CODE_FLAG)
    begin
      r = s.spi_port_b_enable[3'(code - CODE_SPI_B)];
    end
    else if (code >= CODE_FLAG && code < CODE_TW_DATA)
    begin
      r = s.general_flag_pin_enable[4'(code - CODE_FLAG)];
    end
    else if (code == CODE_TW_DATA)
    begin
      r = s.two_wire_data_enable;
    end
    else if (code == CODE_TW_CLK)
    begin
      r = s.two_wire_clock_enable;
    end
    else if (code >= CODE_MISC_HI && code < CODE_RESERVED)
    begin
      r = s.misc_control_out[4'(code - CODE_MISC_HI + MISC_HI_BASE)];
    end
    return r;
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // =====================================================================
  // state
  // =====================================================================
  logic [5:0] sel_ff [NUM_PINS];
  logic [5:0] nxt_sel [NUM_PINS];
  logic [13:0] pullup_ff, nxt_pullup;
  logic [13:0] status_ff, nxt_status;
  logic [13:0] sync1_ff, sync2_ff;
  logic div_ff, nxt_div;
  logic [22:0] prev_src_ff, nxt_prev_src;
  logic [22:0] latch_ff, nxt_latch;
  logic [22:0] rise_mask_ff, nxt_rise_mask;
  logic [22:0] fall_mask_ff, nxt_fall_mask;
  logic [22:0] irq_mask_ff, nxt_irq_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;

  logic take, wr, rd;
  logic [22:0] src, edges, clr;
  logic [31:0] sel_word [NUM_SEL_REGS];
  logic [31:0] rd_word;

  // =====================================================================
  // pin drive path
  // =====================================================================
  // enable mux per pin; two-wire codes force the data low so only the
  // enable moves the line, which keeps the pad open drain
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      pin_oe[p] = sel_enable(sel_ff[p], en_src);
      if (sel_ff[p] == CODE_TW_DATA || sel_ff[p] == CODE_TW_CLK)
      begin
        pin_out[p] = 1'b0;
      end
      else
      begin
        pin_out[p] = pin_buffer_input[p];
      end
    end
  end

  assign pin_pullup = pullup_ff;

  // =====================================================================
  // bus decode
  // =====================================================================
  assign take = wb_req.cyc && wb_req.stb && !ack_ff;
  assign wr = take && wb_req.we;
  assign rd = take && !wb_req.we;

  // packed view of the selection registers, five fields per word, four in the last
  always_comb
  begin
    for (int r = 0; r < NUM_SEL_REGS; r++)
    begin
      sel_word[r] = 32'h0000_0000;
      for (int f = 0; f < FIELDS_PER_REG; f++)
      begin
        if (r * FIELDS_PER_REG + f < NUM_PINS)
        begin
          sel_word[r][f*SEL_W +: SEL_W] = sel_ff[r * FIELDS_PER_REG + f];
        end
      end
    end
  end

  // read mux; unmapped offsets answer zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (wb_req.adr == OFS_SEL0)
    begin
      rd_word = sel_word[0];
    end
    else if (wb_req.adr == OFS_SEL1)
    begin
      rd_word = sel_word[1];
    end
    else if (wb_req.adr == OFS_SEL2)
    begin
      rd_word = sel_word[2];
    end
    else if (wb_req.adr == OFS_PIN_STATUS)
    begin
      rd_word = {18'h00000, status_ff};
    end
    else if (wb_req.adr == OFS_PULLUP)
    begin
      rd_word = {18'h00000, pullup_ff};
    end
    else if (wb_req.adr == OFS_LATCH || wb_req.adr == OFS_LATCH_SHADOW)
    begin
      rd_word = {9'h000, latch_ff};
    end
    else if (wb_req.adr == OFS_RISE_MASK)
    begin
      rd_word = {9'h000, rise_mask_ff};
    end
    else if (wb_req.adr == OFS_FALL_MASK)
    begin
      rd_word = {9'h000, fall_mask_ff};
    end
    else if (wb_req.adr == OFS_IRQ_MASK)
    begin
      rd_word = {9'h000, irq_mask_ff};
    end
  end

  // =====================================================================
  // bus answer: one registered ack per request, dropped next cycle
  // =====================================================================
  always_comb
  begin
    nxt_ack = take;
    nxt_rdata = rdata_ff;
    if (rd)
    begin
      nxt_rdata = rd_word;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // =====================================================================
  // configuration registers
  // =====================================================================
  // written whole word at a time after lane merge; a field that spans
  // two lanes takes only the lanes that were strobed
  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      nxt_sel[p] = sel_ff[p];
    end
    nxt_pullup = pullup_ff;
    nxt_rise_mask = rise_mask_ff;
    nxt_fall_mask = fall_mask_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr)
    begin
      for (int r = 0; r < NUM_SEL_REGS; r++)
      begin
        if (wb_req.adr == OFS_SEL0 + 8'(r * 4))
        begin
          merged = lane_merge(sel_word[r], wb_req.dat, wb_req.sel);
          for (int f = 0; f < FIELDS_PER_REG; f++)
          begin
            if (r * FIELDS_PER_REG + f < NUM_PINS)
            begin
              nxt_sel[r * FIELDS_PER_REG + f] = merged[f*SEL_W +: SEL_W];
            end
          end
        end
      end
      if (wb_req.adr == OFS_PULLUP)
      begin
        merged = lane_merge({18'h00000, pullup_ff}, wb_req.dat, wb_req.sel);
        nxt_pullup = merged[13:0];
      end
      else if (wb_req.adr == OFS_RISE_MASK)
      begin
        merged = lane_merge({9'h000, rise_mask_ff}, wb_req.dat, wb_req.sel);
        nxt_rise_mask = merged[22:0];
      end
      else if (wb_req.adr == OFS_FALL_MASK)
      begin
        merged = lane_merge({9'h000, fall_mask_ff}, wb_req.dat, wb_req.sel);
        nxt_fall_mask = merged[22:0];
      end
      else if (wb_req.adr == OFS_IRQ_MASK)
      begin
        merged = lane_merge({9'h000, irq_mask_ff}, wb_req.dat, wb_req.sel);
        nxt_irq_mask = merged[22:0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        sel_ff[p] <= SEL_RST;
      end
      pullup_ff <= PULLUP_RST;
      rise_mask_ff <= RISE_MASK_RST;
      fall_mask_ff <= FALL_MASK_RST;
      irq_mask_ff <= IRQ_MASK_RST;
    end
    else
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        sel_ff[p] <= nxt_sel[p];
      end
      pullup_ff <= nxt_pullup;
      rise_mask_ff <= nxt_rise_mask;
      fall_mask_ff <= nxt_fall_mask;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // =====================================================================
  // pin status sampling
  // =====================================================================
  // pads are asynchronous, so two flops before anything looks at them;
  // the status copy only moves on every second clock
  always_comb
  begin
    nxt_div = ~div_ff;
    nxt_status = status_ff;
    if (div_ff)
    begin
      nxt_status = sync2_ff;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 14'h0000;
      sync2_ff <= 14'h0000;
      div_ff <= 1'b0;
      status_ff <= 14'h0000;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      div_ff <= nxt_div;
      status_ff <= nxt_status;
    end
  end

  // =====================================================================
  // interrupt controller
  // =====================================================================
  // sources are the sampled pin levels plus the misc control lines;
  // a new edge wins over a clear in the same cycle
  always_comb
  begin
    src = {en_src.misc_control_out, status_ff};
    edges = (src & ~prev_src_ff & rise_mask_ff)
          | (~src & prev_src_ff & fall_mask_ff);
    clr = 23'h000000;
    if (rd && wb_req.adr == OFS_LATCH)
    begin
      clr = 23'h7fffff;
    end
    else if (wr && wb_req.adr == OFS_LATCH)
    begin
      clr = 23'(lane_merge(32'h0000_0000, wb_req.dat, wb_req.sel));
    end
    nxt_latch = (latch_ff & ~clr) | edges;
    nxt_prev_src = src;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      latch_ff <= 23'h000000;
      prev_src_ff <= 23'h000000;
    end
    else
    begin
      latch_ff <= nxt_latch;
      prev_src_ff <= nxt_prev_src;
    end
  end

  // one level output, all unmasked latch bits ored together
  assign combined_interface_interrupt = |(latch_ff & irq_mask_ff);

endmodule

// File: test/pin_route_properties.sv
`timescale 1ns/1ps
// =====================================================================
// port checker for the pin drive routing block
module pin_route_properties
  import pin_route_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // sync reset
  input pin_route_pkg::wb_req_t wb_req, // bus request
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input pin_route_pkg::enable_src_t en_src, // enables
  input wire logic [13:0] pin_buffer_input, // out data
  input wire logic [13:0] pin_out, // pad data
  input wire logic [13:0] pin_oe, // pad enable
  input wire logic [13:0] pin_pullup, // pull-ups
  input wire logic combined_interface_interrupt // interrupt
);
  logic [31:0] sel_ff [3];
  logic [31:0] nxt_sel [3];
  logic [63:0] src_vec;
  logic [13:0] exp_oe, exp_out;
  logic [5:0] code;
  logic take_wr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // selector shadow, taken with the write so it lines up with the registers
  // full-word writes only: byte lanes are not modelled
  assign take_wr = wb_req.cyc & wb_req.stb & ~wb_ack_o & wb_req.we;
  always_comb
    for (int r = 0; r < 3; r++)
      nxt_sel[r] = (take_wr && wb_req.adr == 8'(4 * r)) ? wb_req.dat : sel_ff[r];
  always_ff @(posedge mclk)
    if (!rst_n)
      sel_ff <= '{default: '0};
    else
      sel_ff <= nxt_sel;
  // source vector indexed by code, reserved codes read low
  assign src_vec = {20'h0, en_src.misc_control_out[8:3], en_src.two_wire_clock_enable,
    en_src.two_wire_data_enable, en_src.general_flag_pin_enable, en_src.spi_port_b_enable,
    en_src.spi_port_a_enable, en_src.serial_tx_pin_enable, en_src.timer_pin_enable,
    en_src.misc_control_out[2:0], 2'b10};
  // expected pad enable and data per pin
  always_comb
    for (int i = 0; i < 14; i++)
    begin
      code = sel_ff[i / 5][(i % 5) * 6 +: 6];
      exp_oe[i] = src_vec[code];
      exp_out[i] = (code == 6'h24 || code == 6'h25) ? 1'b0 : pin_buffer_input[i];
    end
  // =====================================================================
  // assertions
  a_ack_single_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle:
    assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_oe_follows_mux:
    assert property (pin_oe == exp_oe)
    else $error("pad enable differs from selected source");
  a_open_drain_data:
    assert property (pin_out == exp_out)
    else $error("pad data wrong for selected code");
  a_pullup_reset_on:
    assert property ($rose(rst_n) |-> pin_pullup == 14'h3fff)
    else $error("pull-ups not all on after reset");
  a_irq_reset_low:
    assert property ($rose(rst_n) |-> !combined_interface_interrupt)
    else $error("interrupt high after reset");
  a_status_upper_zero:
    assert property (wb_ack_o && !wb_req.we && wb_req.adr == 8'h0c |-> wb_dat_o[31:14] == 18'h0)
    else $error("pin status upper bits not zero");
  a_pullup_write_through:
    assert property (take_wr && wb_req.adr == 8'h10 && wb_req.sel == 4'hf
      |=> pin_pullup == $past(wb_req.dat[13:0]))
    else $error("pull-up port not updated by write");
  a_unmapped_reads_zero:
    assert property (wb_ack_o && !wb_req.we && wb_req.adr >= 8'h28 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind peripheral_pin_drive_routing pin_route_properties i_pin_route_properties (
  .mclk(mclk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .en_src(en_src), .pin_buffer_input(pin_buffer_input), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .combined_interface_interrupt(combined_interface_interrupt));

// File: test/pin_board_model.sv
`timescale 1ns/1ps
// =====================================================================
// board side of the fourteen pads
module pin_board_model (
  input wire logic mclk, // clock for the floating pattern
  input wire logic [13:0] pin_out, // pad data from block
  input wire logic [13:0] pin_oe, // pad drive enable
  input wire logic [13:0] pin_pullup, // pull-up enable
  input wire logic [13:0] ext_en, // board drives pad
  input wire logic [13:0] ext_val, // board drive value
  output logic [13:0] pin_level // resolved pad level
);
  logic [13:0] float_ff = '0;
  // undriven pads without pull-up toggle so a stale level never passes
  always @(posedge mclk)
    float_ff <= ~float_ff;
  // block drive wins, then board, then pull-up; two-wire pads only ever pull low
  always_comb
    for (int i = 0; i < 14; i++)
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pin_pullup[i] ? 1'b1 : float_ff[i];
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// self-checking bench for the pin drive routing block
module tb_top;
  import pin_route_pkg::*;
  typedef struct {
    logic [5:0] code;
    int idx;
    logic hot;
    logic cold;
  } row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  wb_req_t wb_req = '0;
  enable_src_t en_src = '0;
  logic [13:0] pin_buffer_input = '0;
  logic [13:0] ext_en = '0;
  logic [13:0] ext_val = '0;
  logic [31:0] wb_dat_o, rd, irq32;
  logic wb_ack_o, combined_interface_interrupt;
  logic [13:0] pin_in, pin_out, pin_oe, pin_pullup;
  int error_cnt = 0;
  int n_tests = 0;
  // code, source bit, enable with only that bit, enable with all but it
  row_t rows[20] = '{
    '{6'h00, 0, 0, 0}, '{6'h01, 0, 1, 1}, '{6'h02, 33, 1, 0}, '{6'h04, 35, 1, 0},
    '{6'h05, 30, 1, 0}, '{6'h07, 32, 1, 0}, '{6'h08, 28, 1, 0}, '{6'h09, 29, 1, 0},
    '{6'h0a, 21, 1, 0}, '{6'h10, 27, 1, 0}, '{6'h11, 14, 1, 0}, '{6'h17, 20, 1, 0},
    '{6'h18, 2, 1, 0}, '{6'h23, 13, 1, 0}, '{6'h24, 1, 1, 0}, '{6'h25, 0, 1, 0},
    '{6'h26, 36, 1, 0}, '{6'h2b, 41, 1, 0}, '{6'h2c, 0, 0, 0}, '{6'h3f, 41, 0, 0}};
  assign irq32 = {31'h0, combined_interface_interrupt};
  // 125 mhz clock
  always #4 mclk = ~mclk;
  // =====================================================================
  // block and board
  peripheral_pin_drive_routing i_peripheral_pin_drive_routing (.mclk(mclk), .rst_n(rst_n),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .en_src(en_src),
    .pin_buffer_input(pin_buffer_input), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .combined_interface_interrupt(combined_interface_interrupt));
  pin_board_model i_pin_board_model (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
  // =====================================================================
  // compare, verdict and bus cycle
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // request stands until ack is sampled; read data is taken at that edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      final_report();
    end
    rd = wb_dat_o;
    wb_req <= '0;
  endtask
  // hang guard, far beyond the real run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  // =====================================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    check(32'(pin_pullup), 32'h3fff);
    check(irq32, 32'h0);
    wb_xfer(1'b0, OFS_PULLUP, 32'h0);
    check(rd, 32'h3fff);
    $display("reset values done");
    pin_buffer_input <= 14'h3fff;
    foreach (rows[r])
    begin
      wb_xfer(1'b1, OFS_SEL0, {2'b00, {5{rows[r].code}}});
      en_src <= enable_src_t'(42'h1 << rows[r].idx);
      @(posedge mclk);
      check(32'(pin_oe[4:0]), {27'h0, {5{rows[r].hot}}});
      en_src <= enable_src_t'(~(42'h1 << rows[r].idx));
      @(posedge mclk);
      check(32'(pin_oe[4:0]), {27'h0, {5{rows[r].cold}}});
      check(32'(pin_out[4:0]), (rows[r].code inside {6'h24, 6'h25}) ? 32'h0 : 32'h1f);
    end
    $display("selector table done");
    // pins 6 and 14 live in the second and third selector words
    en_src <= '0;
    wb_xfer(1'b1, OFS_SEL0, 32'h0);
    wb_xfer(1'b1, OFS_SEL1, 32'h1);
    wb_xfer(1'b1, OFS_SEL2, 32'h1 << 18);
    check(32'(pin_oe), 32'h2020);
    wb_xfer(1'b0, OFS_SEL1, 32'h0);
    check(rd, 32'h1);
    wb_xfer(1'b1, OFS_SEL1, 32'h0);
    wb_xfer(1'b1, OFS_SEL2, 32'h0);
    wb_xfer(1'b1, OFS_PULLUP, 32'h1555);
    check(32'(pin_pullup), 32'h1555);
    $display("selector words and pull-ups done");
    // board drives all pads; status is read-only
    ext_en <= 14'h3fff;
    ext_val <= 14'h2a5a;
    repeat (6) @(posedge mclk);
    wb_xfer(1'b0, OFS_PIN_STATUS, 32'h0);
    check(rd, 32'h2a5a);
    wb_xfer(1'b1, OFS_PIN_STATUS, 32'hffff_ffff);
    wb_xfer(1'b0, OFS_PIN_STATUS, 32'h0);
    check(rd, 32'h2a5a);
    // a pad change read back at once still shows the older sampled copy
    ext_val <= 14'h2a5b;
    wb_xfer(1'b0, OFS_PIN_STATUS, 32'h0);
    check(rd, 32'h2a5a);
    ext_val <= 14'h2a5a;
    repeat (6) @(posedge mclk);
    wb_xfer(1'b0, OFS_PIN_STATUS, 32'h0);
    check(rd, 32'h2a5a);
    $display("pin status done");
    // rising edge on pin 1 armed, falling not
    wb_xfer(1'b1, OFS_RISE_MASK, 32'h4001);
    ext_val <= 14'h2a5b;
    repeat (8) @(posedge mclk);
    check(irq32, 32'h1);
    wb_xfer(1'b0, OFS_LATCH_SHADOW, 32'h0);
    check(rd, 32'h1);
    wb_xfer(1'b0, OFS_LATCH, 32'h0);
    check(rd, 32'h1);
    wb_xfer(1'b0, OFS_LATCH, 32'h0);
    check(rd, 32'h0);
    check(irq32, 32'h0);
    ext_val <= 14'h2a5a;
    repeat (8) @(posedge mclk);
    check(irq32, 32'h0);
    // misc line 0 rises into latch bit 14, then mask and write-one clear
    en_src <= enable_src_t'(42'h1 << 33);
    repeat (3) @(posedge mclk);
    wb_xfer(1'b0, OFS_LATCH_SHADOW, 32'h0);
    check(rd, 32'h4000);
    wb_xfer(1'b1, OFS_IRQ_MASK, 32'h0);
    check(irq32, 32'h0);
    wb_xfer(1'b1, OFS_IRQ_MASK, 32'h7f_ffff);
    check(irq32, 32'h1);
    wb_xfer(1'b1, OFS_LATCH, 32'h4000);
    check(irq32, 32'h0);
    // falling edge only
    wb_xfer(1'b1, OFS_RISE_MASK, 32'h0);
    wb_xfer(1'b1, OFS_FALL_MASK, 32'h1);
    ext_val <= 14'h2a5b;
    repeat (8) @(posedge mclk);
    check(irq32, 32'h0);
    ext_val <= 14'h2a5a;
    repeat (8) @(posedge mclk);
    wb_xfer(1'b0, OFS_LATCH, 32'h0);
    check(rd, 32'h1);
    $display("interrupts done");
    wb_xfer(1'b1, 8'h3c, 32'hffff_ffff);
    wb_xfer(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    check(32'(pin_pullup), 32'h3fff);
    check(irq32, 32'h0);
    // first request right after release; lets the reset assertions see the edge
    wb_xfer(1'b0, OFS_IRQ_MASK, 32'h0);
    check(rd, 32'h7f_ffff);
    $display("unmapped and second reset done");
    final_report();
  end
endmodule
